/* rtl/dpt_device.sv */
/*
 Device end: decodes transfer, status and step frames, holds two wipers
 and their stored setting slots, and times the programming cycle.
 Assumes mode 0 framing; link pins are asynchronous to clk_sys.
*/
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
module dpt_device
	import dpt_pkg::*;
#(
	parameter int         NV_CYC      = NV_WRITE_CYCLES,
	parameter logic [5:0] DEVICE_TYPE = DEV_TYPE_ID
) (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	dpt_spi_if.dev          spi,
	input  wire logic       addr_pin_hi,
	input  wire logic       addr_pin_lo,
	output logic [5:0]      wiper0,
	output logic [5:0]      wiper1,
	output logic            write_in_progress_flag
);
	localparam int NV_W = $clog2(NV_CYC + 1);

	typedef enum logic [3:0] {
		DS_HDR  = 4'h1,
		DS_STEP = 4'h2,
		DS_TX   = 4'h4,
		DS_IGN  = 4'h8
	} dpt_dstate_type;

	dpt_dstate_type state;
	logic            sck_s1;
	logic            sck_s2;
	logic            sck_d;
	logic            cs_s1;
	logic            cs_s2;
	logic            cs_d;
	logic            si_s1;
	logic            si_s2;
	logic [1:0]      addr_s1;
	logic [1:0]      addr_s2;
	logic [4:0]      bit_cnt;
	logic [14:0]     in_sr;
	logic [7:0]      out_sr;
	logic [5:0]      wiper [2];
	logic [5:0]      slot_mem [2][4];
	logic            step_pot;
	logic            nv_pend;
	logic            nv_all;
	logic            nv_pot;
	logic [1:0]      nv_slot;
	logic [NV_W-1:0] nv_cnt;
	logic            prog_busy;
	logic            so_q;

	logic            sck_rise;
	logic            sck_fall;
	logic            cs_rise;
	logic            hdr_done;
	logic [15:0]     frame;
	logic [3:0]      op;
	logic [1:0]      slot;
	logic            pot;
	logic            hit;
	logic            op_ok;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_d  <= 1'b0;
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			cs_d   <= 1'b1;
			si_s1  <= 1'b0;
			si_s2  <= 1'b0;
			addr_s1 <= 2'h0;
			addr_s2 <= 2'h0;
		end else begin
			sck_s1 <= spi.sck;
			sck_s2 <= sck_s1;
			sck_d  <= sck_s2;
			cs_s1  <= spi.cs_n;
			cs_s2  <= cs_s1;
			cs_d   <= cs_s2;
			si_s1  <= spi.si;
			si_s2  <= si_s1;
			addr_s1 <= {addr_pin_hi, addr_pin_lo};
			addr_s2 <= addr_s1;
		end
	end

	assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
	assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;
	assign cs_rise  = cs_s2 & ~cs_d;

	////////////////////////////////////////////////////////////////////////
	// Header capture and decode

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bit_cnt <= 5'h00;
			in_sr   <= 15'h0000;
		end else if (cs_s2) begin
			bit_cnt <= 5'h00;
		end else if (sck_rise) begin
			in_sr <= {in_sr[13:0], si_s2};
			if (bit_cnt != 5'(HDR_BITS))
				bit_cnt <= bit_cnt + 5'h01;
		end
	end

	assign hdr_done = sck_rise && bit_cnt == 5'(HDR_BITS - 1);
	assign frame    = {in_sr, si_s2};
	assign op       = frame[F_OP_LSB +: 4];
	assign slot     = frame[F_SLOT_LSB +: 2];
	assign pot      = frame[F_POT];

	assign hit = frame[F_TYPE_LSB +: 6] == DEVICE_TYPE
		&& frame[F_ADDR_LSB +: 2] == addr_s2
		&& !frame[F_ZERO] && op_ok;

	// Fixed bits of each format must match, else the frame is dropped
	always_comb begin
		unique case (op)
			OP_STATUS:          op_ok = slot == 2'h0 && pot;
			OP_GLOAD, OP_GSAVE: op_ok = !pot;
			OP_STEP:            op_ok = slot == 2'h0;
			OP_LOAD, OP_SAVE:   op_ok = 1'b1;
			default:            op_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state <= DS_HDR;
		end else if (cs_s2) begin
			state <= DS_HDR;
		end else if (hdr_done) begin
			if (hit && op == OP_STATUS)
				state <= DS_TX;
			else if (hit && op == OP_STEP)
				state <= DS_STEP;
			else
				state <= DS_IGN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wiper setting registers

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wiper[0] <= 6'h00;
			wiper[1] <= 6'h00;
			step_pot <= 1'b0;
		end else if (hdr_done && hit) begin
			step_pot <= pot;
			if (op == OP_LOAD)
				wiper[pot] <= slot_mem[pot][slot];
			if (op == OP_GLOAD) begin
				wiper[0] <= slot_mem[0][slot];
				wiper[1] <= slot_mem[1][slot];
			end
		end else if (sck_rise && state == DS_STEP) begin
			wiper[step_pot] <= dpt_step(wiper[step_pot], si_s2);
		end
	end

	assign wiper0 = wiper[0];
	assign wiper1 = wiper[1];

	////////////////////////////////////////////////////////////////////////
	// Stored slots and programming cycle

	// Saves arriving while programming runs are dropped, not queued
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nv_pend <= 1'b0;
			nv_all  <= 1'b0;
			nv_pot  <= 1'b0;
			nv_slot <= 2'h0;
		end else if (cs_rise) begin
			nv_pend <= 1'b0;
		end else if (hdr_done && hit && !prog_busy && (op == OP_SAVE || op == OP_GSAVE)) begin
			nv_pend <= 1'b1;
			nv_all  <= op == OP_GSAVE;
			nv_pot  <= pot;
			nv_slot <= slot;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < 2; p++) begin
				for (int s = 0; s < 4; s++) begin
					slot_mem[p][s] <= 6'h00;
				end
			end
		end else if (cs_rise && nv_pend) begin
			for (int p = 0; p < 2; p++) begin
				if (nv_all || nv_pot == 1'(p))
					slot_mem[p][nv_slot] <= wiper[p];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prog_busy <= 1'b0;
			nv_cnt    <= '0;
		end else if (cs_rise && nv_pend) begin
			prog_busy <= 1'b1;
			nv_cnt    <= NV_W'(NV_CYC - 1);
		end else if (prog_busy) begin
			if (nv_cnt == '0)
				prog_busy <= 1'b0;
			else
				nv_cnt <= nv_cnt - 1'b1;
		end
	end

	assign write_in_progress_flag = prog_busy;

	////////////////////////////////////////////////////////////////////////
	// Status byte out, changed on falling clock

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			out_sr <= 8'h00;
			so_q   <= 1'b0;
		end else if (hdr_done) begin
			// upper bits zero, flag in bit 0
			out_sr <= 8'(prog_busy) << STAT_FLAG;
		end else if (sck_fall && state == DS_TX) begin
			so_q   <= out_sr[7];
			out_sr <= {out_sr[6:0], 1'b0};
		end
	end

	assign spi.so    = so_q;
	assign spi.so_oe = state == DS_TX;
endmodule : dpt_device

/* rtl/dpt_pkg.sv */
/*
 Constants, frame layout and register map shared by both ends of the
 dual potentiometer serial link.
 Assumes a 10 MHz system clock on both ends.
*/
// Function
// - Status read returns byte, flag in bit 0
// - Global load copies chosen slot to wipers
// - Global save writes wipers into chosen slot
// - Single save writes one wiper into slot
// - Single load copies slot into one wiper
// - Step frame then direction bits until deselect
// - Programming starts only after chip select rises
// - Flag shows programming still running
// - Direction high steps up, low steps down
// - Pot select bit picks the wiper
package dpt_pkg;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SCK_PERIOD_NS   = 800;
	localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int NV_WRITE_US     = 5000;
	localparam int NV_WRITE_CYCLES = NV_WRITE_US * 1000 / CLK_PERIOD_NS;
	// Arbitrary device-type prefix value
	localparam logic [5:0] DEV_TYPE_ID = 6'h2B;

	localparam int HDR_BITS  = 16;
	localparam int STAT_BITS = 8;
	localparam int F_TYPE_LSB = 10;
	localparam int F_ADDR_LSB = 8;
	localparam int F_OP_LSB   = 4;
	localparam int F_SLOT_LSB = 2;
	localparam int F_ZERO     = 1;
	localparam int F_POT      = 0;
	localparam int STAT_FLAG  = 0;
	localparam logic [5:0] WIPER_MAX = 6'h3F;

	localparam logic [3:0] OP_STATUS = 4'h5;
	localparam logic [3:0] OP_GLOAD  = 4'h1;
	localparam logic [3:0] OP_GSAVE  = 4'h8;
	localparam logic [3:0] OP_SAVE   = 4'hE;
	localparam logic [3:0] OP_LOAD   = 4'hD;
	localparam logic [3:0] OP_STEP   = 4'h2;

	// Host register byte addresses and fields
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam int C_OP_LSB   = 0;
	localparam int C_SLOT_LSB = 4;
	localparam int C_POT      = 6;
	localparam int C_DIR      = 7;
	localparam int C_CNT_LSB  = 8;
	localparam int C_ADDR_LSB = 14;
	localparam int S_BUSY     = 0;
	localparam int S_FLAG     = 1;
	localparam int S_BYTE_LSB = 8;
	localparam int IRQ_DONE   = 0;

	function automatic logic [5:0] dpt_step(input logic [5:0] w, input logic up);
		if (up && w != WIPER_MAX)
			return w + 6'h01;
		if (!up && w != 6'h00)
			return w - 6'h01;
		return w;
	endfunction : dpt_step
endpackage : dpt_pkg

/* rtl/dpt_spi_if.sv */
/*
 Serial link between the host and the potentiometer device.
 Assumes the bench resolves the shared data-out wire from so_oe.
*/
`timescale 1ns/10ps
interface dpt_spi_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;

	modport dev (
		input  sck,
		input  cs_n,
		input  si,
		output so,
		output so_oe
	);
	modport host (
		output sck,
		output cs_n,
		output si,
		input  so,
		input  so_oe
	);
endinterface : dpt_spi_if

/* rtl/dpt_host.sv */
/*
 Host end: software writes a command word, the host builds and clocks
 the frame, captures the status byte and raises a done interrupt.
 Assumes the register master follows the one-cycle strobe protocol.
*/
`timescale 1ns/10ps
module dpt_host
	import dpt_pkg::*;
#(
	parameter int         HALF        = SCK_HALF_CYCLES,
	parameter logic [5:0] DEVICE_TYPE = DEV_TYPE_ID
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	dpt_spi_if.host          spi,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	output logic             irq
);
	typedef enum logic [3:0] {
		HS_IDLE = 4'h1,
		HS_LOW  = 4'h2,
		HS_HIGH = 4'h4,
		HS_END  = 4'h8
	} dpt_hstate_type;

	dpt_hstate_type state;
	logic [7:0]     ph;
	logic [6:0]     bit_n;
	logic [6:0]     last_bit;
	logic [15:0]    tx_sr;
	logic           fill;
	logic [7:0]     rx_sr;
	logic           was_status;
	logic           so_s1;
	logic           so_s2;
	logic           irq_stat;
	logic           irq_mask;
	logic           done;
	logic           start;
	logic [3:0]     c_op;
	logic [1:0]     c_slot;
	logic           c_pot;
	logic [5:0]     extra;
	logic           ph_end;

	assign start  = wr && addr == REG_CMD && state == HS_IDLE;
	assign c_op   = wdata[C_OP_LSB +: 4];
	// status and step carry zero slot bits
	assign c_slot = (c_op == OP_STATUS || c_op == OP_STEP) ? 2'h0 : wdata[C_SLOT_LSB +: 2];
	assign c_pot  = c_op == OP_STATUS ? 1'b1
		: (c_op == OP_GLOAD || c_op == OP_GSAVE) ? 1'b0 : wdata[C_POT];
	assign extra  = c_op == OP_STATUS ? 6'(STAT_BITS)
		: c_op == OP_STEP ? wdata[C_CNT_LSB +: 6] : 6'h00;
	assign ph_end = ph == 8'(HALF - 1);

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer, clock made by dividing clk_sys

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			so_s1 <= 1'b0;
			so_s2 <= 1'b0;
		end else begin
			so_s1 <= spi.so;
			so_s2 <= so_s1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state      <= HS_IDLE;
			ph         <= 8'h00;
			bit_n      <= 7'h00;
			last_bit   <= 7'h00;
			tx_sr      <= 16'h0000;
			fill       <= 1'b0;
			rx_sr      <= 8'h00;
			was_status <= 1'b0;
			spi.sck    <= 1'b0;
			spi.cs_n   <= 1'b1;
			spi.si     <= 1'b0;
			done       <= 1'b0;
		end else begin
			done <= 1'b0;
			ph   <= (state == HS_IDLE || ph_end) ? 8'h00 : ph + 8'h01;
			unique case (state)
				HS_IDLE: if (start) begin
					tx_sr      <= {DEVICE_TYPE, wdata[C_ADDR_LSB +: 2], c_op, c_slot, 1'b0, c_pot};
					fill       <= c_op == OP_STEP && wdata[C_DIR];
					// Widened so a 63-step frame does not wrap the bit count
					last_bit   <= 7'(HDR_BITS - 1) + 7'(extra);
					was_status <= c_op == OP_STATUS;
					bit_n      <= 7'h00;
					spi.cs_n   <= 1'b0;
					spi.si     <= 1'b0;
					state      <= HS_LOW;
				end
				HS_LOW: begin
					spi.si <= tx_sr[15];
					if (ph_end) begin
						spi.sck <= 1'b1;
						state   <= HS_HIGH;
					end
				end
				HS_HIGH: if (ph_end) begin
					spi.sck <= 1'b0;
					rx_sr   <= {rx_sr[6:0], so_s2};
					tx_sr   <= {tx_sr[14:0], fill};
					bit_n   <= bit_n + 7'h01;
					state   <= bit_n == last_bit ? HS_END : HS_LOW;
				end
				HS_END: if (ph_end) begin
					if (!spi.cs_n) begin
						spi.cs_n <= 1'b1;
					end else begin
						done  <= 1'b1;
						state <= HS_IDLE;
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and interrupt

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_stat <= 1'b0;
			irq_mask <= 1'b0;
		end else begin
			// Set wins over a same-cycle clear
			if (done)
				irq_stat <= 1'b1;
			else if (wr && addr == REG_IRQ_STAT && wdata[IRQ_DONE])
				irq_stat <= 1'b0;
			if (wr && addr == REG_IRQ_MASK)
				irq_mask <= wdata[IRQ_DONE];
		end
	end

	assign irq = irq_stat & irq_mask;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= 32'h0000_0000;
			if (rd) begin
				unique case (addr)
					REG_STATUS: begin
						rdata[S_BUSY]           <= state != HS_IDLE;
						rdata[S_FLAG]           <= was_status & rx_sr[STAT_FLAG];
						rdata[S_BYTE_LSB +: 8]  <= rx_sr;
					end
					REG_IRQ_STAT: rdata[IRQ_DONE] <= irq_stat;
					REG_IRQ_MASK: rdata[IRQ_DONE] <= irq_mask;
					default:      rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : dpt_host

/* verif/dpt_link_asserts.sv */
/*
 Timing checks on the serial link between host and device ends.
 Assumes the host runs with a half period of 4 clocks.
*/
`timescale 1ns/10ps
module dpt_link_asserts (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence high_phase;
		sck [*4];
	endsequence
	sequence gap_phase;
		cs_n [*4];
	endsequence
	////////////////////////////////////////////////////////////////////////
	idle_clock_low_a: assert property (cs_n |-> !sck)
		else $error("sck high while deselected");
	pulse_width_a: assert property ($rose(sck) |-> high_phase)
		else $error("sck high phase too short");
	si_hold_a: assert property ($rose(sck) |-> $stable(si) [*4])
		else $error("si moved while sck high");
	frame_gap_a: assert property ($rose(cs_n) |-> gap_phase)
		else $error("frames too close");
	lead_in_a: assert property ($fell(cs_n) |-> !sck [*4])
		else $error("sck rose too soon after select");
	oe_early_a: assert property ($fell(cs_n) |-> !so_oe [*8])
		else $error("so driven before header decode");
	oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
		else $error("so not released after deselect");
	so_launch_a: assert property (so_oe && $changed(so) |-> !sck)
		else $error("so changed while sck high");
endmodule : dpt_link_asserts

/* verif/dual_pot_spi_transfer_commands_tb.sv */
/*
 Bench joining host and device ends, driven through the host registers.
 Assumes a shortened programming time and a half period of 4 clocks.
*/
`timescale 1ns/10ps
module dual_pot_spi_transfer_commands_tb;
	import dpt_pkg::*;
	localparam int NV = 400;
	logic        clk_sys;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        irq;
	logic [5:0]  wiper0;
	logic [5:0]  wiper1;
	logic        nv_flag;
	logic        addr_pin_hi;
	logic        addr_pin_lo;
	logic [5:0]  e0;
	logic [5:0]  e1;
	logic [31:0] rv;
	int          err_count;
	int          comparisons;
	dpt_spi_if spi ();
	dpt_device #(.NV_CYC(NV)) dpt_device_i (.clk_sys(clk_sys), .rstn(rstn), .spi(spi),
		.addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo), .wiper0(wiper0), .wiper1(wiper1),
		.write_in_progress_flag(nv_flag));
	dpt_host #(.HALF(4)) dpt_host_i (.clk_sys(clk_sys), .rstn(rstn), .spi(spi), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	dpt_link_asserts dpt_link_asserts_i (.clk_sys(clk_sys), .rstn(rstn), .sck(spi.sck), .cs_n(spi.cs_n),
		.si(spi.si), .so(spi.so), .so_oe(spi.so_oe));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask : rd_reg
	function automatic logic [31:0] mk(input logic [3:0] op, input logic [1:0] sl, input logic pot,
		input logic dir, input logic [5:0] n);
		return {16'h0000, 2'b10, n, dir, pot, sl, op};
	endfunction : mk
	task automatic pw(input string what);
		chk(wiper0, e0, what);
		chk(wiper1, e1, what);
	endtask : pw
	// Saves also watch that programming waits for the deselect
	task automatic run(input logic [31:0] cmd, input logic nv);
		int n;
		int hot;
		hot = 0;
		wr_reg(REG_CMD, cmd);
		for (n = 0; n < 3000 && irq !== 1'b1; n++) begin
			tick();
			if (nv && !spi.cs_n && nv_flag) hot++;
		end
		chk(irq, 1'b1, "done irq");
		if (nv) begin
			chk(hot, 0, "flag inside frame");
			chk(nv_flag, 1'b1, "flag after frame");
		end
		wr_reg(REG_IRQ_STAT, 32'h00000001);
		tick();
		chk(irq, 1'b0, "irq cleared");
	endtask : run
	task automatic settle();
		int n;
		for (n = 0; n < 1000 && nv_flag !== 1'b0; n++) tick();
		chk(nv_flag, 1'b0, "flag end");
	endtask : settle
	////////////////////////////////////////////////////////////////////////
	task automatic t_step();
		run(mk(OP_STEP, 2'b00, 1'b0, 1'b1, 6'h05), 1'b0);
		e0 = 6'h05;
		pw("step up pot0");
		run(mk(OP_STEP, 2'b00, 1'b1, 1'b1, 6'h3F), 1'b0);
		run(mk(OP_STEP, 2'b00, 1'b1, 1'b1, 6'h01), 1'b0);
		e1 = 6'h3F;
		pw("step to top pot1");
		run(mk(OP_STEP, 2'b00, 1'b1, 1'b0, 6'h36), 1'b0);
		e1 = 6'h09;
		pw("step down pot1");
		$display("test step done");
	endtask : t_step
	task automatic t_single();
		run(mk(OP_SAVE, 2'b10, 1'b0, 1'b0, 6'h00), 1'b1);
		settle();
		run(mk(OP_STEP, 2'b00, 1'b0, 1'b1, 6'h02), 1'b0);
		run(mk(OP_LOAD, 2'b10, 1'b0, 1'b0, 6'h00), 1'b0);
		pw("single load pot0");
		$display("test single done");
	endtask : t_single
	task automatic t_global();
		run(mk(OP_GSAVE, 2'b01, 1'b0, 1'b0, 6'h00), 1'b1);
		run(mk(OP_STATUS, 2'b00, 1'b1, 1'b0, 6'h00), 1'b0);
		rd_reg(REG_STATUS);
		chk(rv, 32'h00000102, "status busy");
		settle();
		run(mk(OP_STATUS, 2'b00, 1'b1, 1'b0, 6'h00), 1'b0);
		rd_reg(REG_STATUS);
		chk(rv, 32'h00000000, "status idle");
		run(mk(OP_STEP, 2'b00, 1'b1, 1'b1, 6'h03), 1'b0);
		run(mk(OP_GLOAD, 2'b10, 1'b0, 1'b0, 6'h00), 1'b0);
		e1 = 6'h00;
		pw("global load slot2");
		run(mk(OP_GLOAD, 2'b01, 1'b0, 1'b0, 6'h00), 1'b0);
		e1 = 6'h09;
		pw("global load slot1");
		$display("test global done");
	endtask : t_global
	task automatic t_irq();
		run(mk(OP_STEP, 2'b00, 1'b0, 1'b1, 6'h04) ^ 32'h00004000, 1'b0);
		pw("foreign address");
		@(posedge clk_sys);
		addr_pin_lo <= 1'b1;
		run(mk(OP_STEP, 2'b00, 1'b0, 1'b1, 6'h04) ^ 32'h00004000, 1'b0);
		e0 = 6'h09;
		pw("moved address pins");
		@(posedge clk_sys);
		addr_pin_lo <= 1'b0;
		wr_reg(REG_IRQ_MASK, 32'h00000000);
		wr_reg(REG_CMD, mk(OP_STEP, 2'b00, 1'b0, 1'b0, 6'h01));
		repeat (400) tick();
		chk(irq, 1'b0, "masked irq");
		rd_reg(REG_IRQ_STAT);
		chk(rv, 32'h00000001, "sticky done");
		wr_reg(REG_IRQ_MASK, 32'h00000001);
		tick();
		chk(irq, 1'b1, "unmasked irq");
		wr_reg(REG_IRQ_STAT, 32'h00000001);
		tick();
		chk(irq, 1'b0, "cleared irq");
		rd_reg(8'h10);
		chk(rv, 32'h00000000, "unmapped read");
		e0 = 6'h08;
		pw("step down pot0");
		$display("test irq done");
	endtask : t_irq
	task automatic close_out();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
		addr_pin_hi = 1'b1;
		addr_pin_lo = 1'b0;
		err_count = 0;
		comparisons = 0;
		e0 = 6'h00;
		e1 = 6'h00;
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		tick();
		pw("reset wipers");
		wr_reg(REG_IRQ_MASK, 32'h00000001);
		t_step();
		t_single();
		t_global();
		t_irq();
		close_out();
	end
	// Whole run needs about 4400 clocks
	initial begin
		repeat (60000) @(posedge clk_sys);
		err_count++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		close_out();
	end
endmodule : dual_pot_spi_transfer_commands_tb
